/* core/audio_auto_level_control.sv */
// automatic level control: peak detector, gain ramp, limiter, noise gate
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - select field: 00 off, 01 right, 10 left, 11 stereo
// - governed channel ignores manual gain, update, zero-cross and mute
// - compare detected peak with target and steer amplifier gain
// - target code 0000 is -28.5 dBFS, 1.5 dB per code, reset 1011
// - gain never raised above ceiling: 111 is +30 dB, 6 dB per code
// - wait hold delay before ramp up; ramp down at once
// - hold code 0000 is zero, 0001 is 2.67 ms, doubling per code
// - ramp-up time 24 ms at 0000, doubling, saturating from 1010
// - ramp-down time 6 ms at 0000, doubling, saturating from 1010
// - stereo uses larger peak, same gain to both amplifiers
// - single channel drives only its own amplifier gain
// - unused or DC-measurement channels excluded from peak detection
// - zero-cross bit 7 defers gain changes to zero crossings
// - above 87.5% full scale ramp down at fastest attack rate
// - limiter active whenever any channel is under level control
// - gate engages below threshold plus amplifier and boost gain
// - gate threshold 1.5 dB steps, 11110 is -48.75 dBFS
// - gate type X0 freezes gain, 01 mutes output, 11 reserved
// - gate enabled by bit 0, only on level-controlled channels
// - gain is six-bit code, 0.75 dB steps, +30 to -17.25 dB
module audio_auto_level_control #(
  parameter int SAMPLE_W = 16,
  parameter int STEP_CYCLES = level_pkg::STEP_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [level_pkg::ADDR_W-1:0] addr_in,
  input wire logic [level_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [level_pkg::DATA_W-1:0] rdata_out,
  input wire logic sample_valid_in,
  input wire logic [SAMPLE_W-1:0] left_sample_in,
  input wire logic [SAMPLE_W-1:0] right_sample_in,
  input wire logic left_used_in,
  input wire logic right_used_in,
  input wire logic [5:0] boost_steps_in,
  input wire logic [5:0] left_input_gain_in,
  input wire logic [5:0] right_input_gain_in,
  input wire logic left_gain_update_in,
  input wire logic right_gain_update_in,
  input wire logic left_input_silence_in,
  input wire logic right_input_silence_in,
  input wire logic left_zero_cross_in,
  input wire logic right_zero_cross_in,
  output logic [5:0] left_gain_out,
  output logic [5:0] right_gain_out,
  output logic left_gain_update_out,
  output logic right_gain_update_out,
  output logic left_input_silence_out,
  output logic right_input_silence_out,
  output logic left_zero_cross_out,
  output logic right_zero_cross_out,
  output logic left_adc_mute_out,
  output logic right_adc_mute_out
);
  import level_pkg::*;

  function automatic logic [15:0] mag16(input logic [SAMPLE_W-1:0] s);
    logic [SAMPLE_W-1:0] a;
    a = s[SAMPLE_W-1] ? (~s + SAMPLE_W'(1)) : s;
    mag16 = a[SAMPLE_W-1 -: 16];
  endfunction

  // linear magnitude (x64) of level step s
  function automatic logic [31:0] level_lin(input logic [7:0] s);
    logic [6:0] m;
    m = 7'h00;
    case (s[2:0])
      3'h0: m = 7'h2b;
      3'h1: m = 7'h2f;
      3'h2: m = 7'h33;
      3'h3: m = 7'h38;
      3'h4: m = 7'h3d;
      3'h5: m = 7'h42;
      3'h6: m = 7'h48;
      default: m = 7'h4f;
    endcase
    level_lin = 32'(m) << s[7:3];
  endfunction

  function automatic logic [3:0] sat_code(input logic [3:0] c);
    sat_code = (c > CODE_SAT) ? CODE_SAT : c;
  endfunction

  logic [8:0] sel_tgt_reg;
  logic [8:0] zc_hold_reg;
  logic [8:0] ramp_reg;
  logic [8:0] gate_reg;
  logic [8:0] rdata_reg;
  logic [15:0] peak_reg;
  logic [15:0] peak_next;
  logic limit_reg;
  logic limit_next;
  logic gate_on_reg;
  logic [1:0] sign_reg;
  logic [5:0] gain_reg;
  logic [5:0] gain_next;
  logic [TICK_W-1:0] cnt_reg;
  logic [TICK_W-1:0] cnt_next;
  level_state_t state_reg;
  level_state_t state_next;
  logic [5:0] gain_out_reg [2];

  // register fields
  wire [1:0] level_channel_select = sel_tgt_reg[SEL_LSB +: 2];
  wire [2:0] gain_ceiling = sel_tgt_reg[CEIL_LSB +: 3];
  wire [3:0] level_target = sel_tgt_reg[TARGET_LSB +: 4];
  wire level_zero_cross_en = zc_hold_reg[ZC_BIT];
  wire [3:0] hold_delay = zc_hold_reg[HOLD_LSB +: 4];
  wire [3:0] rampup_time = ramp_reg[RAMPUP_LSB +: 4];
  wire [3:0] rampdown_time = ramp_reg[RAMPDOWN_LSB +: 4];
  wire [4:0] gate_threshold = gate_reg[GTH_LSB +: 5];
  wire [1:0] gate_type = gate_reg[GTYPE_LSB +: 2];
  wire gate_enable = gate_reg[GEN_BIT];

  // bit 1 is the left channel, bit 0 the right
  wire [1:0] governed = level_channel_select;
  wire active = |governed;

  // register port decode
  wire hit_sel = (addr_in == SELECT_TARGET_ADDR);
  wire hit_zch = (addr_in == ZC_HOLD_ADDR);
  wire hit_ramp = (addr_in == RAMP_TIMES_ADDR);
  wire hit_gate = (addr_in == GATE_ADDR);
  wire hit_stat = (addr_in == STATUS_ADDR);
  wire [8:0] status_word = {1'b0, limit_reg, gate_on_reg, gain_reg};
  wire [8:0] read_word =
    hit_sel ? sel_tgt_reg :
    hit_zch ? zc_hold_reg :
    hit_ramp ? ramp_reg :
    hit_gate ? gate_reg :
    hit_stat ? status_word : 9'h000;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sel_tgt_reg <= SELECT_TARGET_RST;
      zc_hold_reg <= ZC_HOLD_RST;
      ramp_reg <= RAMP_TIMES_RST;
      gate_reg <= GATE_RST;
    end else if (wr_in) begin
      if (hit_sel) sel_tgt_reg <= wdata_in & SELECT_TARGET_MASK;
      if (hit_zch) zc_hold_reg <= wdata_in & ZC_HOLD_MASK;
      if (hit_ramp) ramp_reg <= wdata_in & RAMP_TIMES_MASK;
      if (hit_gate) gate_reg <= wdata_in & GATE_MASK;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_reg <= 9'h000;
    end else begin
      rdata_reg <= rd_in ? read_word : 9'h000;
    end
  end
  assign rdata_out = rdata_reg;

  // step timebase runs only while a channel is governed
  wire tick;
  level_tick_divider #(
    .DIV(STEP_CYCLES)
  ) u_tick (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .run_in(active),
    .tick_out(tick)
  );

  // peak detection on governed, in-use channels only
  wire [15:0] left_mag = mag16(left_sample_in);
  wire [15:0] right_mag = mag16(right_sample_in);
  wire [1:0] det_use = governed & {left_used_in, right_used_in};
  wire [15:0] left_det = det_use[1] ? left_mag : 16'h0000;
  wire [15:0] right_det = det_use[0] ? right_mag : 16'h0000;
  wire [15:0] cur_mag = (left_det > right_det) ? left_det : right_det;
  wire new_peak = sample_valid_in && (cur_mag > peak_reg);
  wire over_limit = sample_valid_in && (cur_mag > LIMIT_LEVEL);

  // a tick starts a new window; a sample in that cycle seeds it
  always_comb begin
    peak_next = peak_reg;
    limit_next = limit_reg;
    if (tick) begin
      peak_next = sample_valid_in ? cur_mag : 16'h0000;
      limit_next = over_limit;
    end else begin
      if (new_peak) peak_next = cur_mag;
      if (over_limit) limit_next = 1'b1;
    end
    if (!active) begin
      peak_next = 16'h0000;
      limit_next = 1'b0;
    end
  end

  // level comparisons in the x64 linear domain
  wire [31:0] peak_x64 = {10'h000, peak_reg, 6'h00};
  wire [7:0] target_step = TARGET_BASE_STEP + {3'h0, level_target, 1'b0};
  wire above_target = peak_x64 > level_lin(target_step);
  wire [7:0] gate_step = {2'h0, gate_threshold, 1'b0}
    + {2'h0, gain_reg} + {2'h0, boost_steps_in};
  wire gate_hit = active && gate_enable
    && (peak_x64 < level_lin(gate_step));
  wire gate_freeze = gate_on_reg && !gate_type[0];
  wire gate_mute = gate_on_reg && (gate_type == 2'b01);

  // step intervals in ticks
  wire [TICK_W-1:0] down_int = limit_reg ? TICK_W'(1)
    : (TICK_W'(1) << sat_code(rampdown_time));
  wire [TICK_W-1:0] up_int =
    TICK_W'(DECAY_PER_ATTACK) << sat_code(rampup_time);
  wire [3:0] hold_sh = hold_delay - 4'h1;
  wire [TICK_W-1:0] hold_int = (hold_delay == 4'h0) ? '0
    : (TICK_W'(HOLD_BASE_TICKS) << hold_sh);
  wire [5:0] ceil_code = {gain_ceiling, 3'b111};
  wire [TICK_W-1:0] cnt_inc = cnt_reg + TICK_W'(1);
  wire go_down = limit_reg || above_target;
  wire [5:0] manual_sel = governed[1] ? left_input_gain_in
    : right_input_gain_in;

  always_comb begin
    state_next = state_reg;
    gain_next = gain_reg;
    cnt_next = cnt_reg;
    if (!active) begin
      state_next = ST_IDLE;
      cnt_next = '0;
    end else if (state_reg == ST_IDLE) begin
      state_next = ST_HOLD;
      gain_next = manual_sel;
      cnt_next = '0;
    end else if (tick) begin
      if (go_down) begin
        cnt_next = '0;
        if (state_reg != ST_ATTACK || cnt_inc >= down_int) begin
          if (gain_reg != GAIN_MIN) gain_next = gain_reg - 6'h01;
        end else begin
          cnt_next = cnt_inc;
        end
        state_next = ST_ATTACK;
      end else if (gate_freeze) begin
        state_next = state_reg;
      end else begin
        case (state_reg)
          ST_ATTACK: begin
            cnt_next = '0;
            state_next = (hold_int == '0) ? ST_DECAY : ST_HOLD;
          end
          ST_HOLD: begin
            if (cnt_inc >= hold_int) begin
              cnt_next = '0;
              state_next = ST_DECAY;
            end else begin
              cnt_next = cnt_inc;
            end
          end
          ST_DECAY: begin
            if (cnt_inc >= up_int) begin
              cnt_next = '0;
              if (gain_reg < ceil_code && gain_reg != GAIN_MAX) begin
                gain_next = gain_reg + 6'h01;
              end
            end else begin
              cnt_next = cnt_inc;
            end
          end
          default: begin
            state_next = ST_HOLD;
            cnt_next = '0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_IDLE;
      gain_reg <= GAIN_MIN;
      cnt_reg <= '0;
      peak_reg <= 16'h0000;
      limit_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      gain_reg <= gain_next;
      cnt_reg <= cnt_next;
      peak_reg <= peak_next;
      limit_reg <= limit_next;
    end
  end

  // gate decision follows each window
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gate_on_reg <= 1'b0;
    end else if (!active || !gate_enable) begin
      gate_on_reg <= 1'b0;
    end else if (tick) begin
      gate_on_reg <= gate_hit;
    end
  end

  // zero crossing on any governed channel releases a pending gain
  wire [1:0] sign_now = {left_sample_in[SAMPLE_W-1],
    right_sample_in[SAMPLE_W-1]};
  wire crossed = sample_valid_in
    && |((sign_now ^ sign_reg) & governed);
  wire apply = !level_zero_cross_en || crossed;
  wire [5:0] manual_gain [2];
  assign manual_gain[1] = left_input_gain_in;
  assign manual_gain[0] = right_input_gain_in;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sign_reg <= 2'b00;
    end else if (sample_valid_in) begin
      sign_reg <= sign_now;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gain_out_reg[0] <= GAIN_MIN;
      gain_out_reg[1] <= GAIN_MIN;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        if (!governed[ch]) begin
          gain_out_reg[ch] <= manual_gain[ch];
        end else if (apply && state_reg != ST_IDLE) begin
          gain_out_reg[ch] <= gain_reg;
        end
      end
    end
  end

  assign left_gain_out = gain_out_reg[1];
  assign right_gain_out = gain_out_reg[0];
  // manual controls pass only on channels left to software
  assign left_gain_update_out = !governed[1] && left_gain_update_in;
  assign right_gain_update_out = !governed[0] && right_gain_update_in;
  assign left_input_silence_out = !governed[1] && left_input_silence_in;
  assign right_input_silence_out = !governed[0] && right_input_silence_in;
  assign left_zero_cross_out = governed[1] ? level_zero_cross_en
    : left_zero_cross_in;
  assign right_zero_cross_out = governed[0] ? level_zero_cross_en
    : right_zero_cross_in;
  assign left_adc_mute_out = governed[1] && gate_mute;
  assign right_adc_mute_out = governed[0] && gate_mute;
endmodule
`default_nettype wire

/* core/level_pkg.sv */
// constants and types shared by the automatic level control block
package level_pkg;
  // register port
  localparam int ADDR_W = 7;
  localparam int DATA_W = 9;
  localparam logic [6:0] SELECT_TARGET_ADDR = 7'h11;
  localparam logic [6:0] ZC_HOLD_ADDR = 7'h12;
  localparam logic [6:0] RAMP_TIMES_ADDR = 7'h13;
  localparam logic [6:0] GATE_ADDR = 7'h14;
  localparam logic [6:0] STATUS_ADDR = 7'h1c;
  // reset values
  localparam logic [8:0] SELECT_TARGET_RST = 9'h07b;
  localparam logic [8:0] ZC_HOLD_RST = 9'h000;
  localparam logic [8:0] RAMP_TIMES_RST = 9'h032;
  localparam logic [8:0] GATE_RST = 9'h000;
  // writable bits, the rest read as zero
  localparam logic [8:0] SELECT_TARGET_MASK = 9'h1ff;
  localparam logic [8:0] ZC_HOLD_MASK = 9'h08f;
  localparam logic [8:0] RAMP_TIMES_MASK = 9'h0ff;
  localparam logic [8:0] GATE_MASK = 9'h0ff;
  // field positions
  localparam int SEL_LSB = 7;
  localparam int CEIL_LSB = 4;
  localparam int TARGET_LSB = 0;
  localparam int ZC_BIT = 7;
  localparam int HOLD_LSB = 0;
  localparam int RAMPUP_LSB = 4;
  localparam int RAMPDOWN_LSB = 0;
  localparam int GTH_LSB = 3;
  localparam int GTYPE_LSB = 1;
  localparam int GEN_BIT = 0;
  // gain codes, 0.75 dB each, all ones is +30 dB
  localparam logic [5:0] GAIN_MAX = 6'h3f;
  localparam logic [5:0] GAIN_MIN = 6'h00;
  // level scale: step index s is -93.75 dBFS + 0.75 dB * s
  localparam logic [7:0] TARGET_BASE_STEP = 8'h57;
  localparam logic [15:0] LIMIT_LEVEL = 16'h7000;
  // timing
  localparam int CLK_MHZ = 250;
  localparam int ATTACK_MIN_MS = 6;
  localparam int DECAY_MIN_MS = 24;
  localparam int HOLD_MIN_US = 2670;
  localparam int RAMP_STEPS = 57;
  localparam longint STEP_CYCLES_L =
    longint'(ATTACK_MIN_MS) * CLK_MHZ * 1000 / RAMP_STEPS;
  localparam int STEP_CYCLES = int'(STEP_CYCLES_L);
  localparam int HOLD_BASE_TICKS = HOLD_MIN_US * CLK_MHZ / STEP_CYCLES;
  localparam int DECAY_PER_ATTACK = DECAY_MIN_MS / ATTACK_MIN_MS;
  localparam logic [3:0] CODE_SAT = 4'ha;
  localparam int TICK_W = 20;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ATTACK = 2'b01,
    ST_HOLD = 2'b11,
    ST_DECAY = 2'b10
  } level_state_t;
endpackage

/* core/level_tick_divider.sv */
// one-cycle step tick divided down from the core clock
`timescale 1ns/100ps
`default_nettype none
module level_tick_divider #(
  parameter int DIV = 26315
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  output logic tick_out
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] count_reg;
  wire wrap = (count_reg == LAST);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg <= '0;
    end else if (!run_in || wrap) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + CW'(1);
    end
  end
  assign tick_out = run_in && wrap;
endmodule
`default_nettype wire

/* bench/level_checker.sv */
// port assertions for the automatic level control block
`timescale 1ns/100ps
`default_nettype none
module level_checker
  import level_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [level_pkg::ADDR_W-1:0] addr_in,
  input wire logic [level_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [level_pkg::DATA_W-1:0] rdata_out,
  input wire logic [5:0] left_input_gain_in,
  input wire logic [5:0] right_input_gain_in,
  input wire logic left_gain_update_in,
  input wire logic right_input_silence_in,
  input wire logic [5:0] left_gain_out,
  input wire logic [5:0] right_gain_out,
  input wire logic left_gain_update_out,
  input wire logic right_input_silence_out,
  input wire logic left_zero_cross_out,
  input wire logic left_adc_mute_out,
  input wire logic right_adc_mute_out
);
  logic [8:0] st_q;
  logic zc_q;
  logic [1:0] calm_q;
  wire [1:0] sel = st_q[8:7];
  wire calm = calm_q == 2'h3 && !zc_q;
  wire wr_ctl = wr_in && (addr_in == SELECT_TARGET_ADDR ||
    addr_in == ZC_HOLD_ADDR);
  // shadow of the control fields, and cycles since they last changed
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= SELECT_TARGET_RST;
      zc_q <= 1'b0;
      calm_q <= 2'h0;
    end else begin
      if (wr_in && addr_in == SELECT_TARGET_ADDR) begin
        st_q <= wdata_in;
      end
      if (wr_in && addr_in == ZC_HOLD_ADDR) begin
        zc_q <= wdata_in[ZC_BIT];
      end
      calm_q <= wr_ctl ? 2'h0 : (calm_q == 2'h3 ? calm_q : calm_q + 2'h1);
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_stereo_held;
    sel == 2'h3 [*3];
  endsequence
  a_read_target: assert property (rd_in && addr_in == SELECT_TARGET_ADDR
    |=> rdata_out == st_q) else $error("select register read wrong");
  a_read_idle: assert property (!rd_in |=> rdata_out == '0)
    else $error("read data outside read cycle");
  a_off_manual: assert property (sel == 2'h0 && calm_q == 2'h3
    |-> left_gain_out == $past(left_input_gain_in) &&
    right_gain_out == $past(right_input_gain_in))
    else $error("gain not manual while off");
  a_stereo_same: assert property (s_stereo_held
    |-> left_gain_out == right_gain_out) else $error("stereo gains differ");
  a_gov_update: assert property (sel[1] ? !left_gain_update_out
    : left_gain_update_out == left_gain_update_in)
    else $error("manual update pass wrong");
  a_silence_pass: assert property (sel[0] ? !right_input_silence_out
    : right_input_silence_out == right_input_silence_in)
    else $error("manual mute pass wrong");
  a_zc_governed: assert property (sel[1] |-> left_zero_cross_out == zc_q)
    else $error("zero cross not from control");
  a_mute_ungov: assert property ((!sel[1] |-> !left_adc_mute_out) and
    (!sel[0] |-> !right_adc_mute_out)) else $error("mute on free channel");
  a_gain_ceiling: assert property (calm && sel[1] &&
    left_gain_out > $past(left_gain_out)
    |-> left_gain_out <= {st_q[6:4], 3'h7}) else $error("gain above ceiling");
  a_gain_step: assert property (calm && sel[1] && $past(sel[1])
    |-> {1'b0, left_gain_out} <= {1'b0, $past(left_gain_out)} + 7'h1)
    else $error("gain jumped upward");
endmodule
bind audio_auto_level_control level_checker u_level_checker (.*);
`default_nettype wire

/* bench/level_source.sv */
// converter sample stream model with alternating sign samples
`timescale 1ns/100ps
`default_nettype none
module level_source (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [15:0] amp_in,
  output logic valid_out,
  output logic [15:0] left_out,
  output logic [15:0] right_out
);
  logic [1:0] div_q;
  logic pos_q;
  wire [15:0] s = pos_q ? amp_in : -amp_in;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_q <= 2'h0;
      pos_q <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      pos_q <= (div_q == 2'h3) ? !pos_q : pos_q;
    end
  end
  assign valid_out = div_q == 2'h3;
  // outside a frame the lines carry no stale sample
  assign left_out = valid_out ? s : ~s;
  assign right_out = valid_out ? s : ~s;
endmodule
`default_nettype wire

/* bench/test_audio_auto_level_control.sv */
// self-checking bench for the automatic level control block
`timescale 1ns/100ps
`default_nettype none
module test_audio_auto_level_control;
  import level_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [8:0] wdata = 9'h000;
  logic [15:0] amp = 16'h0000;
  logic [5:0] lman = 6'h10;
  logic [5:0] rman = 6'h10;
  logic [5:0] man = 6'h00;
  logic lused = 1'b1;
  logic rused = 1'b1;
  logic [5:0] held;
  logic sv;
  logic [15:0] ls;
  logic [15:0] rs;
  logic [5:0] lg;
  logic [5:0] rg;
  logic [8:0] rdata;
  logic [5:0] pass;
  logic [1:0] mute;
  int err_count = 0;
  int checks = 0;
  always #2 clk = ~clk;
  level_source u_level_source (.clk_in(clk), .rst_n_in(rst_n),
    .amp_in(amp), .valid_out(sv), .left_out(ls), .right_out(rs));
  audio_auto_level_control #(.STEP_CYCLES(8)) u_audio_auto_level_control (
    .clk_in(clk), .rst_n_in(rst_n), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .sample_valid_in(sv),
    .left_sample_in(ls), .right_sample_in(rs), .left_used_in(lused),
    .right_used_in(rused), .boost_steps_in(6'h00),
    .left_input_gain_in(lman), .right_input_gain_in(rman),
    .left_gain_update_in(man[5]), .right_gain_update_in(man[4]),
    .left_input_silence_in(man[3]), .right_input_silence_in(man[2]),
    .left_zero_cross_in(man[1]), .right_zero_cross_in(man[0]),
    .left_gain_out(lg), .right_gain_out(rg),
    .left_gain_update_out(pass[5]), .right_gain_update_out(pass[4]),
    .left_input_silence_out(pass[3]), .right_input_silence_out(pass[2]),
    .left_zero_cross_out(pass[1]), .right_zero_cross_out(pass[0]),
    .left_adc_mute_out(mute[1]), .right_adc_mute_out(mute[0]));
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr9(input logic [6:0] a, input logic [8:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd9(input logic [6:0] a, input logic [8:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic report_and_stop;
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #40000;
    err_count++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd9(SELECT_TARGET_ADDR, SELECT_TARGET_RST);
    rd9(ZC_HOLD_ADDR, 9'h000);
    rd9(RAMP_TIMES_ADDR, 9'h032);
    rd9(GATE_ADDR, 9'h000);
    wr9(7'h15, 9'h1ff);
    rd9(7'h15, 9'h000);
    wr9(ZC_HOLD_ADDR, 9'h1ff);
    rd9(ZC_HOLD_ADDR, 9'h08f);
    wr9(ZC_HOLD_ADDR, 9'h000);
    @(posedge clk);
    lman <= 6'h21;
    rman <= 6'h1c;
    man <= 6'h3f;
    idle(3);
    chk(lg, 6'h21);
    chk(pass, 6'h3f);
    wr9(SELECT_TARGET_ADDR, 9'h10b);
    idle(3);
    chk(rg, 6'h1c);
    chk(pass, 6'h15);
    wr9(SELECT_TARGET_ADDR, 9'h0fb);
    idle(3);
    chk(lg, 6'h21);
    chk(pass, 6'h2a);
    @(posedge clk);
    lman <= 6'h18;
    rman <= 6'h18;
    amp <= 16'h7800;
    wr9(SELECT_TARGET_ADDR, 9'h1fb);
    idle(400);
    chk(lg, GAIN_MIN);
    chk(rg, GAIN_MIN);
    @(posedge clk);
    amp <= 16'h0100;
    wr9(RAMP_TIMES_ADDR, 9'h000);
    wr9(SELECT_TARGET_ADDR, 9'h18b);
    idle(400);
    chk(lg, 6'h07);
    chk(rg, 6'h07);
    wr9(GATE_ADDR, 9'h0f1);
    @(posedge clk);
    amp <= 16'h0001;
    idle(50);
    wr9(SELECT_TARGET_ADDR, 9'h1fb);
    idle(300);
    chk(lg, 6'h07);
    rd9(STATUS_ADDR, 9'h047);
    wr9(GATE_ADDR, 9'h0f3);
    idle(50);
    chk(mute, 2'b11);
    wr9(SELECT_TARGET_ADDR, 9'h07b);
    idle(3);
    chk(mute, 2'b00);
    wr9(GATE_ADDR, 9'h0f7);
    wr9(SELECT_TARGET_ADDR, 9'h1fb);
    idle(50);
    chk(mute, 2'b00);
    // unused channels see a loud signal: no limiter, gain keeps rising
    @(posedge clk);
    lused <= 1'b0;
    rused <= 1'b0;
    amp <= 16'h7800;
    idle(400);
    chk({8'h00, lg < 6'h18}, 9'h000);
    // with zero-cross on and a flat signal the outputs stay put
    wr9(ZC_HOLD_ADDR, 9'h080);
    amp <= 16'h0000;
    idle(20);
    held = lg;
    idle(200);
    chk(lg, held);
    report_and_stop();
  end
endmodule
`default_nettype wire
